/* File: core/shsr_pkg.sv */
// constants and types for the head-return and sense-report command block
// What this block does
// - command bytes 1xh decode as head return
// - head return seeks heads to cylinder 0
// - failed seek sets track-zero-miss error flag
// - command byte 0Bh decodes as sense report
// - stored sense carries standard key/code/qualifier values
// - no stored sense returns all zeros
// - latest command updates sense, except code C3
// - sense report discards stored sense afterwards
// - later completing command overwrites stored sense
// - sense report ignores queued auto-sense setting
// - queued command errors feed stored sense
// - aborts in aborted state keep queued sense
// - non-queued errors also logged for page 10h
// - sense report invalidates logged sense data
// - sense-available bit needs both identify bits plus pending
// - error and sense-available may both be set
// - bit 1 meaningless when identify bit clear
// - qualifier, code, key placed in sector/cylinder registers
// - sense reporting feature disabled after power-up; the block holds no enable state, it follows the id120_sense_en input
package shsr_pkg;
  // command codes
  localparam logic [3:0] CMD_HOME_NIB = 4'h1;
  localparam logic [7:0] CMD_SENSE = 8'h0b;
  localparam logic [7:0] CMD_NO_SENSE_UPD = 8'hc3;
  localparam logic [7:0] LOG_PAGE_SENSE = 8'h10;
  // error register bit positions
  localparam int ERR_ABT = 2;
  localparam int ERR_TZM = 1;
  // status register bit positions
  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_DSC = 4;
  localparam int ST_SDA = 1;
  localparam int ST_ERR = 0;
  // identify word bit used for sense reporting
  localparam int ID_SENSE_BIT = 6;
  // seek timeout: 5 ms at 40 MHz
  localparam int SEEK_TMO_US = 5000;
  localparam int CLK_MHZ = 40;
  localparam int SEEK_TMO_CYC = SEEK_TMO_US * CLK_MHZ;
  localparam int TMO_W = 18;
  // controller states
  typedef enum logic [1:0] {SHSR_IDLE, SHSR_SEEK, SHSR_DONE} shsr_state_t;
endpackage

/* File: core/shsr_decode.sv */
// command byte decoder for the head-return and sense-report commands
`timescale 1ns/100ps
`default_nettype none
module shsr_decode (
  // command byte
  input wire logic [7:0] cmd,
  // decoded classes
  output logic is_home,
  output logic is_sense,
  output logic is_c3
);
  // low nibble is ignored for the head-return family
  assign is_home = (cmd[7:4] == shsr_pkg::CMD_HOME_NIB);
  assign is_sense = (cmd == shsr_pkg::CMD_SENSE);
  assign is_c3 = (cmd == shsr_pkg::CMD_NO_SENSE_UPD);
endmodule
`default_nettype wire

/* File: core/shsr_seek_timer.sv */
// seek watchdog: counts while a seek is in flight, flags timeout
`timescale 1ns/100ps
`default_nettype none
module shsr_seek_timer #(
  parameter int TMO_CYC = shsr_pkg::SEEK_TMO_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // run level and expiry flag, held high while run stays high once the count saturates
  input wire logic run,
  output logic expired
);
  logic [shsr_pkg::TMO_W-1:0] cnt_q;
  // counter clears whenever the seek is not running
  always_ff @(posedge clk) begin
    if (sys_rst || !run) begin
      cnt_q <= '0;
    end else if (cnt_q != shsr_pkg::TMO_W'(TMO_CYC - 1)) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
  assign expired = run && (cnt_q == shsr_pkg::TMO_W'(TMO_CYC - 1));
endmodule
`default_nettype wire

/* File: core/shsr_top.sv */
// head-return and sense-report command interpreter of the drive
`timescale 1ns/100ps
`default_nettype none
module shsr_top #(
  parameter int SEEK_TMO_CYC = shsr_pkg::SEEK_TMO_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // command issue from the task-file front end
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  // identify words 119 and 120 bit 6 (feature supported / enabled)
  input wire logic id119_sense_en,
  input wire logic id120_sense_en,
  // servo interface
  output logic seek_req,
  input wire logic seek_at_zero,
  // other commands completing with sense results
  input wire logic other_done,
  input wire logic [7:0] other_cmd,
  input wire logic other_has_sense,
  input wire logic other_queued,
  input wire logic [3:0] other_key,
  input wire logic [7:0] other_asc,
  input wire logic [7:0] other_ascq,
  input wire logic aborted_state,
  // log read of page 10h
  input wire logic log_rd,
  output logic log_valid,
  output logic [3:0] log_key,
  output logic [7:0] log_asc,
  output logic [7:0] log_ascq,
  // task-file readback
  output logic [7:0] command_error_flags,
  output logic [7:0] device_condition_flags,
  output logic [7:0] sector_number_out,
  output logic [7:0] cylinder_low_out,
  output logic [7:0] cylinder_high_out,
  output logic done
);
  shsr_pkg::shsr_state_t state_q;
  logic is_home, is_sense, is_c3, tmo;
  logic sense_vld_q; // a triplet is stored
  logic sense_queued_q; // stored triplet came from a queued error
  logic [3:0] key_q;
  logic [7:0] asc_q, ascq_q;
  logic take_home, take_sense, upd_other;

  // decode of the host command byte
  shsr_decode u_dec (
    .cmd(cmd_byte),
    .is_home(is_home),
    .is_sense(is_sense),
    .is_c3()
  );
  // decode of the other command that completed
  shsr_decode u_dec_o (
    .cmd(other_cmd),
    .is_home(),
    .is_sense(),
    .is_c3(is_c3)
  );
  // seek watchdog; a shorter timeout can be set for simulation
  shsr_seek_timer #(.TMO_CYC(SEEK_TMO_CYC)) u_tmr (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(state_q == shsr_pkg::SHSR_SEEK),
    .expired(tmo)
  );

  // commands are only taken while idle
  assign take_home = cmd_valid && is_home && (state_q == shsr_pkg::SHSR_IDLE);
  assign take_sense = cmd_valid && is_sense && (state_q == shsr_pkg::SHSR_IDLE);
  // C3 never updates; aborts in the aborted state keep a queued triplet
  assign upd_other = other_done && !is_c3
    && !(aborted_state && sense_queued_q);

  // command sequencer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= shsr_pkg::SHSR_IDLE;
    end else begin
      unique case (state_q)
        shsr_pkg::SHSR_IDLE: begin
          if (take_home) begin
            state_q <= shsr_pkg::SHSR_SEEK;
          end else if (take_sense) begin
            state_q <= shsr_pkg::SHSR_DONE;
          end
        end
        shsr_pkg::SHSR_SEEK: begin
          if (seek_at_zero || tmo) begin
            state_q <= shsr_pkg::SHSR_DONE;
          end
        end
        shsr_pkg::SHSR_DONE: begin
          state_q <= shsr_pkg::SHSR_IDLE;
        end
        // the unused fourth code falls back to idle rather than locking up
        default: begin
          state_q <= shsr_pkg::SHSR_IDLE;
        end
      endcase
    end
  end
  // heads are driven toward cylinder 0 for the whole seek
  assign seek_req = (state_q == shsr_pkg::SHSR_SEEK);
  assign done = (state_q == shsr_pkg::SHSR_DONE);

  // error flags, latched per command
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      command_error_flags <= '0;
    end else if (take_home || take_sense) begin
      command_error_flags <= '0;
    end else if (state_q == shsr_pkg::SHSR_SEEK && tmo && !seek_at_zero) begin
      command_error_flags[shsr_pkg::ERR_TZM] <= 1'b1;
    end
  end

  // stored sense triplet; a new result wins over the read-clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sense_vld_q <= 1'b0;
      sense_queued_q <= 1'b0;
      key_q <= '0;
      asc_q <= '0;
      ascq_q <= '0;
    end else if (upd_other) begin
      sense_vld_q <= other_has_sense;
      sense_queued_q <= other_queued && other_has_sense;
      key_q <= other_has_sense ? other_key : 4'h0;
      asc_q <= other_has_sense ? other_asc : 8'h00;
      ascq_q <= other_has_sense ? other_ascq : 8'h00;
    end else if (take_sense) begin
      sense_vld_q <= 1'b0;
      sense_queued_q <= 1'b0;
      key_q <= '0;
      asc_q <= '0;
      ascq_q <= '0;
    end
  end

  // sense report loads the readback registers; independent of auto-sense
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sector_number_out <= '0;
      cylinder_low_out <= '0;
      cylinder_high_out <= '0;
    end else if (take_sense) begin
      sector_number_out <= sense_vld_q ? ascq_q : 8'h00;
      cylinder_low_out <= sense_vld_q ? asc_q : 8'h00;
      cylinder_high_out <= {4'h0, sense_vld_q ? key_q : 4'h0};
    end
  end

  // log page copy of non-queued error sense; dropped on sense report
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      log_valid <= 1'b0;
      log_key <= '0;
      log_asc <= '0;
      log_ascq <= '0;
    end else if (other_done && other_has_sense && !other_queued) begin
      log_valid <= 1'b1;
      log_key <= other_key;
      log_asc <= other_asc;
      log_ascq <= other_ascq;
    end else if (take_sense) begin
      log_valid <= 1'b0;
    end
  end

  // status: busy while seeking, error on abort or miss, sense-available
  always_comb begin
    device_condition_flags = '0;
    device_condition_flags[shsr_pkg::ST_BSY] = (state_q == shsr_pkg::SHSR_SEEK);
    device_condition_flags[shsr_pkg::ST_RDY] = 1'b1;
    device_condition_flags[shsr_pkg::ST_DSC] = (state_q != shsr_pkg::SHSR_SEEK);
    device_condition_flags[shsr_pkg::ST_ERR] = command_error_flags[shsr_pkg::ERR_ABT]
      || command_error_flags[shsr_pkg::ERR_TZM];
    // bit 1 left zero when the feature is off; via identify inputs
    device_condition_flags[shsr_pkg::ST_SDA] = id119_sense_en && id120_sense_en
      && sense_vld_q;
  end

  // checks
  tzm_after_tmo_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == shsr_pkg::SHSR_SEEK && tmo && !seek_at_zero)
    |=> command_error_flags[shsr_pkg::ERR_TZM] && done)
    else $error("track zero miss not flagged");
  sense_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    (take_sense && !upd_other) |=> !sense_vld_q)
    else $error("sense not discarded");
  sda_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    device_condition_flags[shsr_pkg::ST_SDA] |-> (id119_sense_en && id120_sense_en))
    else $error("sense available without feature");
  c3_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    (other_done && is_c3 && !take_sense) |=> $stable(key_q) && $stable(asc_q))
    else $error("c3 updated sense");
  sense_out_a: assert property (@(posedge clk) disable iff (sys_rst)
    (take_sense && sense_vld_q) |=> cylinder_low_out == $past(asc_q)
    && sector_number_out == $past(ascq_q))
    else $error("sense fields misplaced");
  sense_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    (take_sense && !sense_vld_q) |=> cylinder_high_out == 8'h00)
    else $error("empty sense not zero");
  home_seek_a: assert property (@(posedge clk) disable iff (sys_rst)
    take_home |=> seek_req)
    else $error("head return did not seek");
  log_inval_a: assert property (@(posedge clk) disable iff (sys_rst)
    (take_sense && !(other_done && other_has_sense && !other_queued)) |=> !log_valid)
    else $error("log sense kept after report");
  busy_done_a: assert property (@(posedge clk) disable iff (sys_rst)
    done |-> !device_condition_flags[shsr_pkg::ST_BSY])
    else $error("busy at completion");
endmodule
`default_nettype wire

/* File: verif/shsr_servo_model.sv */
// servo stand-in: brings the heads to cylinder 0 promptly, slowly or never
`timescale 1ns/100ps
`default_nettype none
module shsr_servo_model (
  // clock and answer mode
  input wire logic clk,
  input wire logic [1:0] mode,
  // seek handshake
  input wire logic seek_req,
  output logic seek_at_zero
);
  logic [3:0] cnt_q; // cycles spent in the current seek

  // count only while a seek is requested, so every seek starts from zero
  always_ff @(posedge clk) begin
    cnt_q <= seek_req ? cnt_q + 4'h1 : 4'h0;
  end

  // mode 0 answers after 1 cycle, mode 1 after 6, mode 2 is a stuck actuator
  assign seek_at_zero = seek_req && (mode != 2'h2) &&
    (cnt_q >= ((mode == 2'h0) ? 4'h1 : 4'h6));
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// self-checking bench for the head-return and sense-report block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
  // stimulus, all driven 2 ns after the rising edge
  logic clk = 0, sys_rst = 1, cmd_valid = 0, other_done = 0, other_has_sense = 0;
  logic other_queued = 0, aborted_state = 0, seek_req, seek_at_zero, done, log_valid;
  logic [7:0] cmd_byte = 0, other_cmd = 0, other_asc = 0, other_ascq = 0;
  logic [3:0] other_key = 0, log_key;
  logic [7:0] log_asc, log_ascq, err, stat, sec, cyl_lo, cyl_hi;
  logic [1:0] mode = 0; // servo answer speed
  logic id_en = 1; // identify word 120 bit 6, dropped at the end
  logic [31:0] exp_q[$]; // expected {error, readback} per completion
  logic [31:0] e_m;
  logic [23:0] last_rb = 0; // readback stands until the next sense report
  logic [19:0] k1, k2;
  int mismatches = 0, num_checks = 0, seed = 9795, cycles = 0, m;

  always #12.5 clk = ~clk;

  // short timeout so a seek watchdog run stays brief
  shsr_top #(.SEEK_TMO_CYC(16)) i_dut (.clk, .sys_rst, .cmd_valid, .cmd_byte,
    .id119_sense_en(1'b1), .id120_sense_en(id_en), .seek_req, .seek_at_zero,
    .other_done, .other_cmd, .other_has_sense, .other_queued, .other_key, .other_asc,
    .other_ascq, .aborted_state, .log_rd(1'b1), .log_valid, .log_key, .log_asc,
    .log_ascq, .command_error_flags(err), .device_condition_flags(stat),
    .sector_number_out(sec), .cylinder_low_out(cyl_lo), .cylinder_high_out(cyl_hi), .done);

  shsr_servo_model i_servo (.clk, .mode, .seek_req, .seek_at_zero);

  task automatic print_verdict();
    if (mismatches == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watcher: every completion pulse retires the oldest note
  always @(posedge clk) begin
    if (done === 1'b1) begin
      e_m = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hx;
      `CHK("readback", e_m, {err, cyl_hi, cyl_lo, sec})
    end
  end

  // a hang counts as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles > 2000) begin
      mismatches++;
      print_verdict();
    end
  end

  // one command, held a single cycle, then wait for its completion pulse
  task automatic cmd(input logic [7:0] c, input logic [7:0] e_err);
    int n;
    exp_q.push_back({e_err, last_rb});
    cmd_byte = c;
    cmd_valid = 1;
    @(posedge clk) #2;
    cmd_valid = 0;
    for (n = 0; n < 40 && done !== 1'b1; n++) @(posedge clk) #2;
    @(posedge clk) #2;
  endtask

  task automatic sense(input logic [23:0] rb);
    last_rb = rb;
    cmd(8'h0b, 8'h00);
  endtask

  // another command completes carrying a sense triplet
  task automatic other(input logic [7:0] c, input logic q, input logic [19:0] sense_triplet);
    other_cmd = c;
    other_queued = q;
    other_has_sense = 1;
    {other_key, other_asc, other_ascq} = sense_triplet;
    other_done = 1;
    @(posedge clk) #2;
    other_done = 0;
    other_has_sense = 0;
    // fields no longer valid: show something else
    {other_key, other_asc, other_ascq} = ~sense_triplet;
    @(posedge clk) #2;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    #2 sys_rst = 0;
    `CHK("status", 8'h50, stat)
    `CHK("error", 8'h00, err)
    k1 = 20'($random(seed));
    k2 = 20'($random(seed));
    sense(24'h0);
    other(8'h25, 1'b0, k1);
    `CHK("avail", 1'b1, stat[shsr_pkg::ST_SDA])
    `CHK("log", {1'b1, k1}, {log_valid, log_key, log_asc, log_ascq})
    sense({4'h0, k1});
    `CHK("log_valid", 1'b0, log_valid)
    `CHK("avail", 1'b0, stat[shsr_pkg::ST_SDA])
    sense(24'h0);
    other(8'h25, 1'b0, k1);
    other(8'h35, 1'b0, k2);
    other(8'hc3, 1'b0, k1);
    sense({4'h0, k2});
    other(8'h60, 1'b1, k1);
    aborted_state = 1;
    other(8'h25, 1'b0, k2);
    aborted_state = 0;
    sense({4'h0, k1});
    other(8'h25, 1'b0, k2);
    // prompt, slow and stuck servo; any low nibble must decode
    for (m = 0; m < 3; m++) begin
      mode = 2'(m);
      cmd({4'h1, 4'($random(seed))}, (m == 2) ? 8'h02 : 8'h00);
      `CHK("err_bit", (m == 2), stat[shsr_pkg::ST_ERR])
    end
    `CHK("avail_err", 1'b1, stat[shsr_pkg::ST_SDA])
    id_en = 0;
    @(posedge clk) #2;
    `CHK("avail_off", 1'b0, stat[shsr_pkg::ST_SDA])
    `CHK("drained", 0, exp_q.size())
    print_verdict();
  end
endmodule
`default_nettype wire
